// ### hdl/frs_scheduler.sv
// fixed-pattern calibration scheduler with status indicator
//
// Notes on behaviour
// RULE_01 - policy off: never calibrate automatically; only explicit commands start one (a pending deferred run still starts on acq_start).
// RULE_02 - external target selected forces automatic policy to off.
// RULE_03 - temperature policy: request recal when drift exceeds limit.
// RULE_04 - time policy: request recal when elapsed seconds exceed interval.
// RULE_05 - combined policy: request when either drift or time condition holds.
// RULE_06 - automatic runs never closer than minimum spacing.
// RULE_07 - due while acquisition stopped: status becomes deferred.
// RULE_08 - acquisition start with pending: calibrate first, then deliver frames.
// RULE_09 - on-demand triggering with no triggers during calibration: fail with timeout.
// RULE_10 - host supplies triggers at normal rate during on-demand calibration.
// RULE_11 - triggering off or continuous readout: frames acquired without triggers.
// RULE_12 - scene source selection picks internal shutter or external target.
// RULE_13 - save command writes user coefficients to non-volatile memory.
// RULE_14 - user correction applies on top of factory correction.
// RULE_15 - red from power-up; stays red only on fatal error.
// RULE_16 - blue once address assigned; host accepted only from then.
// RULE_17 - successful calibration records temperature and restarts elapsed timer.
// RULE_18 - internal target: shutter closed during calibration, reopened after.
`timescale 1ns/10ps
module frs_scheduler #(
  parameter int unsigned CYC_PER_SEC   = frs_pkg::CYCLES_PER_SEC,
  parameter int unsigned SHUTTER_CYC   = frs_pkg::SHUTTER_CYCLES,
  parameter int unsigned TRIG_WAIT     = frs_pkg::TRIG_WAIT_CYC,
  parameter int unsigned N_FRAMES      = frs_pkg::CALIB_FRAMES
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire frs_pkg::frs_cfg_t           cfg,
  input  wire logic                        calib_command,
  input  wire logic                        save_command,
  input  wire logic                        acq_start,
  input  wire logic                        acq_stop,
  input  wire logic                        frame_done,
  input  wire logic                        trigger_pin,
  input  wire logic [frs_pkg::TEMP_W-1:0]  sensor_temp,
  input  wire logic                        init_started,
  input  wire logic                        fatal_error,
  input  wire logic                        addr_assigned,
  input  wire logic                        nvm_ack,
  output frs_pkg::frs_status_t             calib_status,
  output logic                             calib_busy,
  output logic                             shutter_close,
  output logic                             frame_out_en,
  output logic                             free_run_acq,
  output logic                             nvm_write,
  output logic                             user_corr_apply,
  output logic                             factory_corr_apply,
  output logic                             host_accept,
  output frs_pkg::frs_led_t                led_state,
  output frs_pkg::frs_policy_t             effective_policy
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic trig_sync;
  logic trig_prev;
  logic trig_edge;

  frs_sync #(.W(1)) u_trig_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (trigger_pin),
    .sync_out (trig_sync)
  );

  assign trig_edge = trig_sync & ~trig_prev;

  // ----------------------------------------------------------------
  // policy and acquisition mode
  // ----------------------------------------------------------------
  logic on_demand;

  always_comb begin
    if (cfg.uniform_scene_source_sel == frs_pkg::SRC_EXTERNAL) begin
      effective_policy = frs_pkg::FRS_POL_OFF; // [RULE_02]
    end else begin
      effective_policy = cfg.auto_recal_policy;
    end
  end

  // continuous acquisition unless triggered on-demand readout
  assign on_demand    = cfg.trigger_gate_setting &&
                        (cfg.exposure_alignment_sel == frs_pkg::ALIGN_ODR);
  assign free_run_acq = ~on_demand; // [RULE_11]

  // ----------------------------------------------------------------
  // elapsed-time and reference temperature
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FRS_FSM_IDLE    = 3'b000,
    FRS_FSM_CLOSE   = 3'b001,
    FRS_FSM_COLLECT = 3'b011,
    FRS_FSM_OPEN    = 3'b010,
    FRS_FSM_SAVE    = 3'b110
  } frs_fsm_t;

  frs_fsm_t                   state;
  frs_fsm_t                   next_state;
  logic [31:0]                sec_div;
  logic [31:0]                next_sec_div;
  logic [frs_pkg::SEC_W-1:0]  elapsed_s;
  logic [frs_pkg::SEC_W-1:0]  next_elapsed_s;
  logic [frs_pkg::SEC_W-1:0]  since_auto_s;
  logic [frs_pkg::SEC_W-1:0]  next_since_auto_s;
  logic [frs_pkg::TEMP_W-1:0] ref_temp;
  logic [frs_pkg::TEMP_W-1:0] next_ref_temp;
  logic                       calib_ok;
  logic                       auto_start;
  logic                       sec_tick;

  assign sec_tick = (sec_div == CYC_PER_SEC - 1);

  always_comb begin
    next_sec_div      = sec_tick ? 32'h0 : sec_div + 32'h1;
    next_elapsed_s    = elapsed_s;
    next_since_auto_s = since_auto_s;
    next_ref_temp     = ref_temp;
    if (sec_tick && elapsed_s != '1) begin
      next_elapsed_s = elapsed_s + 1'b1;
    end
    if (sec_tick && since_auto_s != '1) begin
      next_since_auto_s = since_auto_s + 1'b1;
    end
    if (auto_start) begin
      next_since_auto_s = '0; // [RULE_06]
    end
    if (calib_ok) begin
      next_elapsed_s = '0;          // [RULE_17]
      next_ref_temp  = sensor_temp; // [RULE_17]
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sec_div      <= 32'h0;
      elapsed_s    <= '0;
      since_auto_s <= '1;
      ref_temp     <= '0;
      trig_prev    <= 1'b0;
    end else begin
      sec_div      <= next_sec_div;
      elapsed_s    <= next_elapsed_s;
      since_auto_s <= next_since_auto_s;
      ref_temp     <= next_ref_temp;
      trig_prev    <= trig_sync;
    end
  end

  // ----------------------------------------------------------------
  // due conditions
  // ----------------------------------------------------------------
  logic [frs_pkg::TEMP_W-1:0] drift;
  logic                       drift_hit;
  logic                       time_hit;
  logic                       due;
  logic                       spacing_ok;

  assign drift      = (sensor_temp > ref_temp) ? sensor_temp - ref_temp
                                                : ref_temp - sensor_temp;
  assign drift_hit  = drift > cfg.max_temp_drift_limit; // [RULE_03]
  assign time_hit   = elapsed_s > cfg.max_recal_interval_s; // [RULE_04]
  assign spacing_ok = since_auto_s >= cfg.min_recal_spacing; // [RULE_06]

  always_comb begin
    case (effective_policy)
      frs_pkg::FRS_POL_TEMP:   due = drift_hit;
      frs_pkg::FRS_POL_TIME:   due = time_hit;
      frs_pkg::FRS_POL_EITHER: due = drift_hit | time_hit; // [RULE_05]
      default:                 due = 1'b0; // [RULE_01]
    endcase
  end

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  logic                 acquiring;
  logic                 next_acquiring;
  logic                 pending;
  logic                 next_pending;
  logic [31:0]          wait_cnt;
  logic [31:0]          next_wait_cnt;
  logic [7:0]           frames;
  logic [7:0]           next_frames;
  logic                 save_req;
  logic                 next_save_req;
  frs_pkg::frs_status_t next_status;
  logic                 go_manual;
  logic                 auto_due;
  logic                 use_shutter;
  logic                 frame_evt;

  assign go_manual   = calib_command && host_accept;
  assign auto_due    = due && spacing_ok && state == FRS_FSM_IDLE;
  assign use_shutter = cfg.uniform_scene_source_sel == frs_pkg::SRC_INTERNAL; // [RULE_12]
  assign frame_evt   = on_demand ? trig_edge : frame_done;

  always_comb begin
    next_state     = state;
    next_acquiring = acquiring;
    next_pending   = pending;
    next_wait_cnt  = wait_cnt;
    next_frames    = frames;
    next_status    = calib_status;
    next_save_req  = save_req | (save_command & host_accept);
    auto_start     = 1'b0;
    calib_ok       = 1'b0;
    if (acq_start) begin
      next_acquiring = 1'b1;
    end else if (acq_stop) begin
      next_acquiring = 1'b0;
    end
    case (state)
      FRS_FSM_IDLE: begin
        if (go_manual || (pending && (acq_start || acquiring)) || (auto_due && acquiring)) begin
          auto_start    = !go_manual;
          next_pending  = 1'b0;
          next_state    = use_shutter ? FRS_FSM_CLOSE : FRS_FSM_COLLECT; // [RULE_18]
          next_wait_cnt = 32'h0;
          next_frames   = 8'h0;
          next_status   = frs_pkg::FRS_ST_RUNNING;
        end else if (auto_due && !acquiring && !pending) begin
          next_pending = 1'b1;
          next_status  = frs_pkg::FRS_ST_DEFERRED; // [RULE_07]
        end else if (save_req) begin
          next_state = FRS_FSM_SAVE;
        end
      end
      FRS_FSM_CLOSE: begin
        next_wait_cnt = wait_cnt + 32'h1;
        if (wait_cnt == SHUTTER_CYC - 1) begin
          next_state    = FRS_FSM_COLLECT;
          next_wait_cnt = 32'h0;
        end
      end
      FRS_FSM_COLLECT: begin
        next_wait_cnt = wait_cnt + 32'h1;
        if (frame_evt) begin
          next_frames   = frames + 8'h1;
          next_wait_cnt = 32'h0;
        end
        if (frame_evt && frames == 8'(N_FRAMES - 1)) begin
          calib_ok      = 1'b1;
          next_status   = frs_pkg::FRS_ST_DONE;
          next_wait_cnt = 32'h0;
          next_state    = use_shutter ? FRS_FSM_OPEN : FRS_FSM_IDLE;
        end else if (on_demand && !frame_evt && wait_cnt == TRIG_WAIT - 1) begin
          next_status   = frs_pkg::FRS_ST_TIMEOUT; // [RULE_09]
          next_wait_cnt = 32'h0;
          next_state    = use_shutter ? FRS_FSM_OPEN : FRS_FSM_IDLE;
        end
      end
      FRS_FSM_OPEN: begin
        next_wait_cnt = wait_cnt + 32'h1;
        if (wait_cnt == SHUTTER_CYC - 1) begin
          next_state = FRS_FSM_IDLE; // [RULE_18]
        end
      end
      FRS_FSM_SAVE: begin
        if (nvm_ack) begin
          next_save_req = save_command & host_accept; // [RULE_13]
          next_state    = FRS_FSM_IDLE;
        end
      end
      default: next_state = FRS_FSM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state        <= FRS_FSM_IDLE;
      acquiring    <= 1'b0;
      pending      <= 1'b0;
      wait_cnt     <= 32'h0;
      frames       <= 8'h0;
      save_req     <= 1'b0;
      calib_status <= frs_pkg::FRS_ST_IDLE;
    end else begin
      state        <= next_state;
      acquiring    <= next_acquiring;
      pending      <= next_pending;
      wait_cnt     <= next_wait_cnt;
      frames       <= next_frames;
      save_req     <= next_save_req;
      calib_status <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // outputs and status indicator
  // ----------------------------------------------------------------
  frs_pkg::frs_led_t next_led;
  logic              next_host_accept;
  logic              next_frame_out;

  always_comb begin
    next_led         = led_state;
    next_host_accept = 1'b0;
    if (fatal_error) begin
      next_led         = frs_pkg::FRS_LED_RED; // [RULE_15]
      next_host_accept = 1'b0;
    end else if (addr_assigned) begin
      next_led         = frs_pkg::FRS_LED_BLUE; // [RULE_16]
      next_host_accept = 1'b1;                  // [RULE_16]
    end else if (init_started) begin
      next_led = frs_pkg::FRS_LED_FLASH_BLUE;
    end
    // frames held back until a pending or running calibration finishes
    next_frame_out = next_acquiring && next_state == FRS_FSM_IDLE && !next_pending; // [RULE_08]
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      led_state    <= frs_pkg::FRS_LED_RED; // [RULE_15]
      host_accept  <= 1'b0;
      frame_out_en <= 1'b0;
    end else begin
      led_state    <= next_led;
      host_accept  <= next_host_accept;
      frame_out_en <= next_frame_out;
    end
  end

  assign calib_busy         = state != FRS_FSM_IDLE && state != FRS_FSM_SAVE;
  assign shutter_close      = state == FRS_FSM_CLOSE || state == FRS_FSM_COLLECT && use_shutter;
  assign nvm_write          = state == FRS_FSM_SAVE; // [RULE_13]
  assign factory_corr_apply = 1'b1;                  // [RULE_14]
  assign user_corr_apply    = cfg.user_corr_en;      // [RULE_14]

endmodule : frs_scheduler

// ### pkg/frs_pkg.sv
// package: constants and types for the recalibration scheduler
package frs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned SECOND_NS       = 1_000_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned CYCLES_PER_SEC  = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned SHUTTER_MOVE_MS = 10;
  localparam int unsigned SHUTTER_CYCLES  = SHUTTER_MOVE_MS * (CLK_HZ / 1000);
  localparam int unsigned CALIB_FRAMES    = 4;
  localparam int unsigned TRIG_WAIT_MS    = 2000;
  localparam int unsigned TRIG_WAIT_CYC   = TRIG_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned NVM_WAIT_CYC    = 1;

  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int unsigned TEMP_W = 12;
  localparam int unsigned SEC_W  = 16;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FRS_POL_OFF   = 2'h0,
    FRS_POL_TEMP  = 2'h1,
    FRS_POL_TIME  = 2'h2,
    FRS_POL_EITHER = 2'h3
  } frs_policy_t;

  typedef enum logic [2:0] {
    FRS_ST_IDLE     = 3'h0,
    FRS_ST_RUNNING  = 3'h1,
    FRS_ST_DONE     = 3'h2,
    FRS_ST_TIMEOUT  = 3'h3,
    FRS_ST_DEFERRED = 3'h4
  } frs_status_t;

  typedef enum logic [1:0] {
    FRS_LED_OFF  = 2'h0,
    FRS_LED_RED  = 2'h1,
    FRS_LED_FLASH_BLUE = 2'h2,
    FRS_LED_BLUE = 2'h3
  } frs_led_t;

  // configuration from host features
  typedef struct packed {
    frs_policy_t             auto_recal_policy;
    logic [TEMP_W-1:0]       max_temp_drift_limit;
    logic [SEC_W-1:0]        max_recal_interval_s;
    logic [SEC_W-1:0]        min_recal_spacing;
    logic                    uniform_scene_source_sel;
    logic                    exposure_alignment_sel;
    logic                    trigger_gate_setting;
    logic                    user_corr_en;
  } frs_cfg_t;

  localparam logic SRC_INTERNAL = 1'b0;
  localparam logic SRC_EXTERNAL = 1'b1;
  localparam logic ALIGN_CONT   = 1'b0;
  localparam logic ALIGN_ODR    = 1'b1;

endpackage : frs_pkg

// ### hdl/frs_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module frs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  always_comb begin
    next_stage1 = async_in;
    next_sync   = stage1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync;
    end
  end
endmodule : frs_sync

// ### tb/frs_checker.sv
// checker: concurrent properties for the recalibration scheduler
`timescale 1ns/10ps
module frs_checker (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire frs_pkg::frs_cfg_t    cfg,
  input wire logic                 calib_command,
  input wire logic                 acq_start,
  input wire logic                 fatal_error,
  input wire logic                 addr_assigned,
  input wire logic                 nvm_write,
  input wire frs_pkg::frs_status_t calib_status,
  input wire logic                 calib_busy,
  input wire logic                 shutter_close,
  input wire logic                 frame_out_en,
  input wire logic                 user_corr_apply,
  input wire logic                 factory_corr_apply,
  input wire logic                 host_accept,
  input wire frs_pkg::frs_led_t    led_state,
  input wire frs_pkg::frs_policy_t effective_policy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_cmd_taken;
    calib_command && host_accept && !calib_busy && !nvm_write;
  endsequence
  sequence s_new_run;
    calib_status == frs_pkg::FRS_ST_RUNNING && $past(calib_status) != frs_pkg::FRS_ST_RUNNING;
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_cmd_starts_run: assert property (s_cmd_taken |=> calib_status == frs_pkg::FRS_ST_RUNNING)
    else $error("manual command did not start a run");
  a_off_no_auto: assert property (s_new_run ##0 effective_policy == frs_pkg::FRS_POL_OFF
    |-> $past(calib_command) || $past(acq_start)) else $error("run started by itself");
  a_ext_forces_off: assert property (effective_policy == (cfg.uniform_scene_source_sel ?
    frs_pkg::FRS_POL_OFF : cfg.auto_recal_policy)) else $error("effective policy wrong");
  a_ext_no_shutter: assert property (cfg.uniform_scene_source_sel |-> !shutter_close)
    else $error("shutter closed with external target");
  a_idle_shutter_open: assert property (!calib_busy |-> !shutter_close)
    else $error("shutter closed while idle");
  a_corr_stacked: assert property (factory_corr_apply && user_corr_apply == cfg.user_corr_en)
    else $error("correction enables wrong");
  a_fatal_red: assert property (fatal_error [*4] |-> led_state == frs_pkg::FRS_LED_RED)
    else $error("indicator not red on fatal error");
  a_addr_blue: assert property ((addr_assigned && !fatal_error) [*4]
    |-> led_state == frs_pkg::FRS_LED_BLUE && host_accept) else $error("not blue after address");
  a_host_gated: assert property (!addr_assigned [*4] |-> !host_accept)
    else $error("host accepted without address");
  a_deferred_first: assert property (calib_status == frs_pkg::FRS_ST_DEFERRED && acq_start
    |=> calib_status == frs_pkg::FRS_ST_RUNNING && !frame_out_en) else $error("frames before run");
  a_timeout_odr_only: assert property (calib_status == frs_pkg::FRS_ST_TIMEOUT &&
    $past(calib_status) != frs_pkg::FRS_ST_TIMEOUT |-> cfg.exposure_alignment_sel &&
    cfg.trigger_gate_setting) else $error("timeout outside on-demand mode");
endmodule : frs_checker

bind frs_scheduler frs_checker u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .calib_command(calib_command),
  .acq_start(acq_start), .fatal_error(fatal_error), .addr_assigned(addr_assigned),
  .nvm_write(nvm_write), .calib_status(calib_status), .calib_busy(calib_busy),
  .shutter_close(shutter_close), .frame_out_en(frame_out_en),
  .user_corr_apply(user_corr_apply), .factory_corr_apply(factory_corr_apply),
  .host_accept(host_accept), .led_state(led_state), .effective_policy(effective_policy));

// ### tb/frs_host_model.sv
// partner model: sensor frame pulses and host trigger pin
`timescale 1ns/10ps
module frs_host_model #(
  parameter int unsigned PERIOD = 6
) (
  input  wire logic core_clk,
  input  wire logic frames_on,
  input  wire logic trig_on,
  output logic      frame_done,
  output logic      trigger_pin
);
  int unsigned cnt = 0;
  initial begin
    frame_done = 1'b0;
    trigger_pin = 1'b0;
  end
  // one fixed rate, so calibration sees the same trigger spacing as normal use
  always @(negedge core_clk) begin
    cnt <= (cnt + 1) % PERIOD;
    frame_done <= frames_on && cnt == 0;
    trigger_pin <= trig_on && cnt < PERIOD / 2;
  end
endmodule : frs_host_model

// ### tb/tb.sv
// testbench: self-checking run of the recalibration scheduler
`timescale 1ns/10ps
module tb;
  localparam int unsigned CPS = 20;
  localparam int unsigned SHC = 4;
  typedef struct packed {
    logic [1:0] pol;
    logic       src;
    logic       uce;
    logic [1:0] eff;
  } frs_row_t;
  frs_row_t rows [8] = '{'{2'h0,1'b0,1'b1,2'h0}, '{2'h1,1'b0,1'b0,2'h1},
    '{2'h2,1'b0,1'b1,2'h2}, '{2'h3,1'b0,1'b0,2'h3}, '{2'h0,1'b1,1'b0,2'h0},
    '{2'h1,1'b1,1'b1,2'h0}, '{2'h2,1'b1,1'b0,2'h0}, '{2'h3,1'b1,1'b1,2'h0}};
  logic core_clk, sys_rst, calib_command, save_command, acq_start, acq_stop, nvm_ack;
  logic init_started, fatal_error, addr_assigned, frames_on, trig_on, frame_done;
  logic trigger_pin, calib_busy, shutter_close, frame_out_en, free_run_acq, nvm_write;
  logic user_corr_apply, factory_corr_apply, host_accept;
  logic [frs_pkg::TEMP_W-1:0] sensor_temp;
  frs_pkg::frs_cfg_t          cfg;
  frs_pkg::frs_status_t       calib_status;
  frs_pkg::frs_led_t          led_state;
  frs_pkg::frs_policy_t       effective_policy;
  int unsigned                err_total = 0, comparisons = 0, cyc = 0, t0;

  frs_scheduler #(.CYC_PER_SEC(CPS), .SHUTTER_CYC(SHC), .TRIG_WAIT(50), .N_FRAMES(4)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .calib_command(calib_command),
    .save_command(save_command), .acq_start(acq_start), .acq_stop(acq_stop),
    .frame_done(frame_done), .trigger_pin(trigger_pin), .sensor_temp(sensor_temp),
    .init_started(init_started), .fatal_error(fatal_error), .addr_assigned(addr_assigned),
    .nvm_ack(nvm_ack), .calib_status(calib_status), .calib_busy(calib_busy),
    .shutter_close(shutter_close), .frame_out_en(frame_out_en), .free_run_acq(free_run_acq),
    .nvm_write(nvm_write), .user_corr_apply(user_corr_apply),
    .factory_corr_apply(factory_corr_apply), .host_accept(host_accept),
    .led_state(led_state), .effective_policy(effective_policy));
  frs_host_model #(.PERIOD(6)) u_host (.core_clk(core_clk), .frames_on(frames_on),
    .trig_on(trig_on), .frame_done(frame_done), .trigger_pin(trigger_pin));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : pulse
  // bounded wait; running out ends the run
  task automatic wait_st(input frs_pkg::frs_status_t st, input int unsigned lim);
    int unsigned n;
    n = 0;
    while (calib_status !== st && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk("calib_status", st, calib_status);
    if (calib_status !== st) stop_test();
  endtask : wait_st
  task automatic wait_free;
    int unsigned n;
    n = 0;
    while (calib_busy !== 1'b0 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk("calib_busy", 0, calib_busy);
    if (calib_busy !== 1'b0) stop_test();
  endtask : wait_free

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {calib_command, save_command, acq_start, acq_stop, nvm_ack, trig_on} = '0;
    {init_started, fatal_error, addr_assigned, frames_on} = '0;
    sensor_temp = 12'h064;
    cfg = '0;
    cfg.max_temp_drift_limit = 12'hfff;
    cfg.max_recal_interval_s = 16'hffff;
    sys_rst = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("calib_status", frs_pkg::FRS_ST_IDLE, calib_status);
    chk("led_state", frs_pkg::FRS_LED_RED, led_state);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      cfg.auto_recal_policy = frs_pkg::frs_policy_t'(rows[i].pol);
      cfg.uniform_scene_source_sel = rows[i].src;
      cfg.user_corr_en = rows[i].uce;
      @(negedge core_clk);
      chk("effective_policy", rows[i].eff, effective_policy);
      chk("user_corr_apply", rows[i].uce, user_corr_apply);
      chk("factory_corr_apply", 1, factory_corr_apply);
    end
    cfg.auto_recal_policy = frs_pkg::FRS_POL_OFF;
    cfg.uniform_scene_source_sel = frs_pkg::SRC_INTERNAL;
    $display("test done: rows");
    init_started = 1'b1;
    pulse(calib_command);
    repeat (3) @(negedge core_clk);
    chk("calib_status", frs_pkg::FRS_ST_IDLE, calib_status);
    chk("led_state", frs_pkg::FRS_LED_FLASH_BLUE, led_state);
    addr_assigned = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("host_accept", 1, host_accept);
    $display("test done: indicator");
    frames_on = 1'b1;
    pulse(acq_start);
    chk("free_run_acq", 1, free_run_acq);
    pulse(calib_command);
    chk("calib_status", frs_pkg::FRS_ST_RUNNING, calib_status);
    chk("shutter_close", 1, shutter_close);
    wait_st(frs_pkg::FRS_ST_DONE, 100);
    wait_free();
    chk("shutter_close", 0, shutter_close);
    cfg.auto_recal_policy = frs_pkg::FRS_POL_TEMP;
    cfg.max_temp_drift_limit = 12'h005;
    cfg.min_recal_spacing = 16'h0000;
    sensor_temp = 12'h069;
    repeat (2 * CPS) @(negedge core_clk);
    chk("calib_status", frs_pkg::FRS_ST_DONE, calib_status);
    sensor_temp = 12'h06a;
    wait_st(frs_pkg::FRS_ST_RUNNING, 5);
    wait_st(frs_pkg::FRS_ST_DONE, 100);
    wait_free();
    cfg.auto_recal_policy = frs_pkg::FRS_POL_TIME;
    cfg.max_recal_interval_s = 16'h0002;
    t0 = cyc;
    wait_st(frs_pkg::FRS_ST_RUNNING, 3 * CPS + 4);
    chk("interval_early", 1, (cyc - t0) > 2 * CPS - 2 * SHC);
    wait_st(frs_pkg::FRS_ST_DONE, 100);
    wait_free();
    cfg.auto_recal_policy = frs_pkg::FRS_POL_EITHER;
    cfg.max_recal_interval_s = 16'hffff;
    sensor_temp = 12'h070;
    wait_st(frs_pkg::FRS_ST_RUNNING, 5);
    t0 = cyc;
    cfg.auto_recal_policy = frs_pkg::FRS_POL_TIME;
    cfg.max_recal_interval_s = 16'h0000;
    cfg.min_recal_spacing = 16'h0005;
    wait_st(frs_pkg::FRS_ST_DONE, 100);
    wait_st(frs_pkg::FRS_ST_RUNNING, 6 * CPS);
    chk("spacing", 1, (cyc - t0) > 4 * CPS);
    wait_free();
    cfg.auto_recal_policy = frs_pkg::FRS_POL_OFF;
    $display("test done: auto policies");
    pulse(acq_stop);
    frames_on = 1'b0;
    cfg.min_recal_spacing = 16'h0000;
    cfg.auto_recal_policy = frs_pkg::FRS_POL_TIME;
    wait_st(frs_pkg::FRS_ST_DEFERRED, 3 * CPS);
    frames_on = 1'b1;
    pulse(acq_start);
    cfg.auto_recal_policy = frs_pkg::FRS_POL_OFF;
    chk("calib_status", frs_pkg::FRS_ST_RUNNING, calib_status);
    chk("frame_out_en", 0, frame_out_en);
    wait_st(frs_pkg::FRS_ST_DONE, 100);
    wait_free();
    chk("frame_out_en", 1, frame_out_en);
    repeat (3 * CPS) @(negedge core_clk);
    chk("calib_status", frs_pkg::FRS_ST_DONE, calib_status);
    $display("test done: deferred");
    frames_on = 1'b0;
    cfg.exposure_alignment_sel = frs_pkg::ALIGN_ODR;
    cfg.trigger_gate_setting = 1'b1;
    pulse(calib_command);
    chk("free_run_acq", 0, free_run_acq);
    wait_st(frs_pkg::FRS_ST_TIMEOUT, SHC + 70);
    wait_free();
    trig_on = 1'b1;
    cfg.uniform_scene_source_sel = frs_pkg::SRC_EXTERNAL;
    pulse(calib_command);
    chk("shutter_close", 0, shutter_close);
    wait_st(frs_pkg::FRS_ST_DONE, 100);
    wait_free();
    $display("test done: triggers");
    pulse(save_command);
    @(negedge core_clk);
    chk("nvm_write", 1, nvm_write);
    pulse(nvm_ack);
    chk("nvm_write", 0, nvm_write);
    pulse(calib_command);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("calib_status", frs_pkg::FRS_ST_IDLE, calib_status);
    chk("host_accept", 0, host_accept);
    sys_rst = 1'b0;
    fatal_error = 1'b1;
    repeat (5) @(negedge core_clk);
    chk("led_state", frs_pkg::FRS_LED_RED, led_state);
    $display("test done: save and fatal");
    stop_test();
  end
endmodule : tb
